//--- inc/sfesc_defines.svh
// Purpose: constants of the erase and suspend command handler
// Assumes: 200 MHz system clock
// Notes: opcodes are the one-byte instruction codes on the link
`ifndef SFESC_DEFINES_SVH
`define SFESC_DEFINES_SVH
// timing
`define SFESC_CLK_MHZ 200
`define SFESC_SUSP_LAT_NS 20000
// longest time, so the count rounds down
`define SFESC_SUSP_LAT_CYC ((`SFESC_SUSP_LAT_NS * `SFESC_CLK_MHZ) / 1000)
// opcodes
`define SFESC_OP_BLK_ERASE 8'hd8
`define SFESC_OP_BLK_ERASE_WIDE 8'hdc
`define SFESC_OP_CE_A 8'h60
`define SFESC_OP_CE_B 8'hc7
`define SFESC_OP_SUSP 8'h75
`define SFESC_OP_RESUME 8'h7a
`define SFESC_OP_WR_ENABLE 8'h06
`define SFESC_OP_WRDI 8'h04
`define SFESC_OP_CLSR 8'h30
`define SFESC_OP_READ 8'h03
`define SFESC_OP_READ4 8'h13
`define SFESC_OP_FREAD 8'h0b
`define SFESC_OP_PP 8'h02
`define SFESC_OP_PP4 8'h12
`define SFESC_OP_QPP 8'h32
`define SFESC_OP_QPP4 8'h34
`define SFESC_OP_ECC_STAT_WIDE 8'h18
// bit counts of a command frame
`define SFESC_OPC_BITS 7'h08
`define SFESC_ADDR3_BITS 7'h18
`define SFESC_ADDR4_BITS 7'h20
`define SFESC_CNT_MAX 7'h7f
// address fields: 8 MB blocks of eight 1 MB sectors
`define SFESC_BLK_LSB 23
`define SFESC_BLK_MSB 25
`define SFESC_SECS_PER_BLK 6'h08
`define SFESC_LAST_SEC_CHIP 6'h3f
`endif

//--- inc/sfesc_pkg.sv
// Purpose: types of the erase and suspend command handler
// Assumes: constants live in sfesc_defines.svh
// Notes: none
package sfesc_pkg;
  // erase engine states
  typedef enum logic [1:0] {
    SFESC_IDLE,
    SFESC_ERASING,
    SFESC_SUSPENDING,
    SFESC_SUSPENDED
  } sfesc_state_t;
  // request to the array: one sector step at a time
  typedef struct packed {
    logic valid;   // held until the array reports done or a suspend is taken
    logic erase;   // 0 pre-program, 1 erase to 00h
    logic [5:0] sector;
  } sfesc_arr_req_t;
  // command handed to the other command handlers
  typedef struct packed {
    logic valid;   // one-cycle pulse at frame end
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [6:0] bits;
  } sfesc_cmd_t;
  // status bits
  typedef struct packed {
    logic work_in_progress_bit;
    logic erase_suspended;
    logic erase_err;
    logic prog_err;
    logic write_enable_latch;
  } sfesc_status_t;
endpackage

//--- design/sfesc_ctrl.sv
// Purpose: serial flash block/chip erase with suspend and resume of block erase
// Assumes: link clock at most a quarter of clk_sys_i; modes 0 and 3
// Notes: link pins are sampled through two flops before any use
`timescale 1ns/1ps
`include "sfesc_defines.svh"
module sfesc_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sclk_i,                  // link clock pin
  input wire logic cs_n_i,                  // chip select, active low
  input wire logic [3:0] io_i,              // io lanes, lane 0 is serial in
  input wire logic quad_command_mode_i,     // four-lane commands
  input wire logic addr_len4_i,             // address length config bit
  input wire logic [7:0] block_prot_i,      // one protect bit per block
  input wire logic prog_busy_i,             // program engine busy
  input wire logic arr_done_i,              // array step finished pulse
  output sfesc_pkg::sfesc_arr_req_t arr_req_o,
  output sfesc_pkg::sfesc_cmd_t cmd_fwd_o,
  output sfesc_pkg::sfesc_status_t status_o,
  output logic read_undef_o                 // read hits suspended block
);

  // whole module state
  typedef struct packed {
    logic [2:0] sclk_s;         // sync chain plus edge stage
    logic [2:0] cs_s;
    logic [3:0] io_s0;          // first io stage
    logic [3:0] io_s1;          // second io stage
    logic [6:0] bits;           // bits taken this frame, saturating
    logic [7:0] opc;            // opcode shifter
    logic [31:0] addr;          // address shifter
    sfesc_pkg::sfesc_state_t st;
    logic chip;                 // running erase is a chip erase
    logic phase;                // 0 pre-program, 1 erase
    logic [5:0] sec;            // current sector
    logic [5:0] last;           // final sector of the erase
    logic [2:0] sblk;           // block being erased
    logic [11:0] lat;           // suspend latency countdown
    logic we_latch;             // write enable latch
    logic es;
    logic eerr;
    logic perr;
    logic rd_undef;
    sfesc_pkg::sfesc_cmd_t fwd;
  } sfesc_ctrl_t;

  sfesc_ctrl_t s_r;
  sfesc_ctrl_t s_nxt;

  // address bits that follow an opcode
  function automatic logic [6:0] addr_bits(input logic [7:0] op, input logic a4);
    logic [6:0] r;
    r = 7'h00;
    unique case (op)
      `SFESC_OP_BLK_ERASE_WIDE, `SFESC_OP_READ4, `SFESC_OP_PP4, `SFESC_OP_QPP4,
      `SFESC_OP_ECC_STAT_WIDE, 8'hcf:
        r = `SFESC_ADDR4_BITS;
      `SFESC_OP_BLK_ERASE, `SFESC_OP_READ, `SFESC_OP_FREAD, `SFESC_OP_PP,
      `SFESC_OP_QPP, 8'h19, 8'hce:
        r = a4 ? `SFESC_ADDR4_BITS : `SFESC_ADDR3_BITS;
      default:
        r = 7'h00;
    endcase
    return r;
  endfunction

  // commands that may run while an erase is suspended
  function automatic logic susp_ok(input logic [7:0] op);
    logic r;
    r = 1'b0;
    unique case (op)
      8'h75, 8'h7a, 8'h03, 8'h13, 8'h0b: r = 1'b1;
      8'h05, 8'h07, 8'h65: r = 1'b1;
      8'h35, 8'h15, 8'h33, 8'h19, 8'h18: r = 1'b1;
      8'h1b, 8'h4c, 8'h9f, 8'haf, 8'hc3, 8'h5a, 8'h77: r = 1'b1;
      8'h06, 8'h04, 8'h02, 8'h12, 8'h32, 8'h34, 8'hce, 8'hcf: r = 1'b1;
      8'h30, 8'h66, 8'h99: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // array read opcodes
  function automatic logic is_read(input logic [7:0] op);
    return op == `SFESC_OP_READ || op == `SFESC_OP_READ4 || op == `SFESC_OP_FREAD
      || op == 8'h19 || op == `SFESC_OP_ECC_STAT_WIDE;
  endfunction

  // array program opcodes
  function automatic logic is_prog(input logic [7:0] op);
    return op == `SFESC_OP_PP || op == `SFESC_OP_PP4 || op == `SFESC_OP_QPP
      || op == `SFESC_OP_QPP4;
  endfunction

  // next-state logic
  always_comb
  begin
    logic rise;
    logic frame_end;
    logic [6:0] step;
    logic [6:0] alen;
    logic [2:0] blk;
    logic suspended;
    rise = 1'b0;
    frame_end = 1'b0;
    step = 7'h00;
    alen = 7'h00;
    blk = 3'h0;
    suspended = 1'b0;
    s_nxt = s_r;
    // pins through two flops; edge stage reads only the second
    s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk_i};
    s_nxt.cs_s = {s_r.cs_s[1:0], cs_n_i};
    s_nxt.io_s0 = io_i;
    s_nxt.io_s1 = s_r.io_s0;
    rise = s_r.sclk_s[1] & ~s_r.sclk_s[2] & ~s_r.cs_s[1];
    frame_end = s_r.cs_s[1] & ~s_r.cs_s[2];
    step = quad_command_mode_i ? 7'h04 : 7'h01;
    alen = addr_bits(s_r.opc, addr_len4_i);
    blk = s_r.addr[`SFESC_BLK_MSB:`SFESC_BLK_LSB];
    suspended = (s_r.st == sfesc_pkg::SFESC_SUSPENDED);
    s_nxt.fwd.valid = 1'b0;

    // shift opcode then address on link clock rises
    if (rise)
    begin
      if (s_r.bits < `SFESC_OPC_BITS)
      begin
        if (quad_command_mode_i)
          s_nxt.opc = {s_r.opc[3:0], s_r.io_s1};
        else
          s_nxt.opc = {s_r.opc[6:0], s_r.io_s1[0]};
      end
      else if (s_r.bits < `SFESC_OPC_BITS + alen)
      begin
        if (quad_command_mode_i)
          s_nxt.addr = {s_r.addr[27:0], s_r.io_s1};
        else
          s_nxt.addr = {s_r.addr[30:0], s_r.io_s1[0]};
      end
      if (s_r.bits <= `SFESC_CNT_MAX - step)
        s_nxt.bits = s_r.bits + step;
      else
        s_nxt.bits = `SFESC_CNT_MAX;
    end

    // erase engine, one sector step per array handshake
    unique case (s_r.st)
      sfesc_pkg::SFESC_IDLE:
        s_nxt.lat = 12'h000;
      sfesc_pkg::SFESC_ERASING, sfesc_pkg::SFESC_SUSPENDING:
      begin
        if (s_r.st == sfesc_pkg::SFESC_SUSPENDING)
        begin
          // stop within the latency, then report suspended
          if (s_r.lat != 12'h000)
            s_nxt.lat = s_r.lat - 12'h001;
          else
          begin
            s_nxt.st = sfesc_pkg::SFESC_SUSPENDED;
            s_nxt.es = 1'b1;
          end
        end
        if (arr_done_i)
        begin
          if (!s_r.phase)
            s_nxt.phase = 1'b1;
          else if (s_r.sec == s_r.last)
          begin
            // erase finished; completion beats a pending stop
            s_nxt.st = sfesc_pkg::SFESC_IDLE;
            s_nxt.es = 1'b0;
            s_nxt.we_latch = 1'b0;
          end
          else
          begin
            s_nxt.sec = s_r.sec + 6'h01;
            s_nxt.phase = 1'b0;
          end
        end
      end
      sfesc_pkg::SFESC_SUSPENDED:
        s_nxt.lat = 12'h000;
    endcase

    // read inside the suspended block gives undefined data
    s_nxt.rd_undef = (suspended || s_r.st == sfesc_pkg::SFESC_SUSPENDING)
      && is_read(s_r.opc) && s_r.bits >= `SFESC_OPC_BITS + alen
      && blk == s_r.sblk && !s_r.cs_s[1];

    // act on the command when chip select rises
    if (frame_end)
    begin
      s_nxt.bits = 7'h00;
      s_nxt.addr = 32'h0000_0000;
      s_nxt.rd_undef = 1'b0;
      // forward what the current state admits
      s_nxt.fwd.opcode = s_r.opc;
      s_nxt.fwd.addr = s_r.addr;
      s_nxt.fwd.bits = s_r.bits;
      s_nxt.fwd.valid = (s_r.st == sfesc_pkg::SFESC_IDLE) || susp_ok(s_r.opc);
      unique case (s_r.opc)
        `SFESC_OP_WR_ENABLE:
          if (s_r.bits == `SFESC_OPC_BITS)
            s_nxt.we_latch = 1'b1;
        `SFESC_OP_WRDI:
          if (s_r.bits == `SFESC_OPC_BITS)
            s_nxt.we_latch = 1'b0;
        `SFESC_OP_CLSR:
        begin
          // no other opcode branch can set an error bit in the same cycle as this clear
          s_nxt.eerr = 1'b0;
          s_nxt.perr = 1'b0;
        end
        `SFESC_OP_BLK_ERASE, `SFESC_OP_BLK_ERASE_WIDE:
          // only an exact frame with the latch set is taken
          if (s_r.st == sfesc_pkg::SFESC_IDLE && s_r.we_latch
              && s_r.bits == `SFESC_OPC_BITS + alen)
          begin
            s_nxt.we_latch = 1'b0;
            if (block_prot_i[blk])
              s_nxt.eerr = 1'b1;
            else
            begin
              s_nxt.st = sfesc_pkg::SFESC_ERASING;
              s_nxt.chip = 1'b0;
              s_nxt.sblk = blk;
              s_nxt.sec = {blk, 3'h0};
              s_nxt.last = {blk, 3'h0} + `SFESC_SECS_PER_BLK - 6'h01;
              s_nxt.phase = 1'b0;
              s_nxt.we_latch = 1'b1; // latch set for the erase; cleared at its end or by WRDI
            end
          end
        `SFESC_OP_CE_A, `SFESC_OP_CE_B:
          if (s_r.st == sfesc_pkg::SFESC_IDLE && s_r.we_latch
              && s_r.bits == `SFESC_OPC_BITS)
          begin
            s_nxt.we_latch = 1'b0;
            if (|block_prot_i)
              s_nxt.eerr = 1'b1;
            else
            begin
              s_nxt.st = sfesc_pkg::SFESC_ERASING;
              s_nxt.chip = 1'b1;
              s_nxt.sec = 6'h00;
              s_nxt.last = `SFESC_LAST_SEC_CHIP;
              s_nxt.phase = 1'b0;
              s_nxt.we_latch = 1'b1;
            end
          end
        `SFESC_OP_SUSP:
          // other states: nothing changes
          if (s_r.st == sfesc_pkg::SFESC_ERASING && !s_r.chip
              && s_r.bits == `SFESC_OPC_BITS)
          begin
            s_nxt.st = sfesc_pkg::SFESC_SUSPENDING;
            s_nxt.lat = 12'(`SFESC_SUSP_LAT_CYC - 1);
          end
        `SFESC_OP_RESUME:
          if (suspended && !prog_busy_i
              && s_r.bits == `SFESC_OPC_BITS)
          begin
            s_nxt.st = sfesc_pkg::SFESC_ERASING;
            s_nxt.es = 1'b0;
          end
        default:
          // program into the suspended block fails
          if (suspended && is_prog(s_r.opc) && blk == s_r.sblk
              && s_r.bits > `SFESC_OPC_BITS + alen)
          begin
            s_nxt.perr = 1'b1;
            s_nxt.fwd.valid = 1'b0;
          end
      endcase
      // erase ending in this very cycle: start path above already saw busy
      if (s_nxt.st == sfesc_pkg::SFESC_IDLE && s_r.st != sfesc_pkg::SFESC_IDLE)
        s_nxt.we_latch = 1'b0;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.sclk_s <= 3'h0;
      s_r.cs_s <= 3'h7;  // deselected
      s_r.st <= sfesc_pkg::SFESC_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // array step request, held until done or a suspend is taken
  assign arr_req_o.valid = (s_r.st == sfesc_pkg::SFESC_ERASING);
  assign arr_req_o.erase = s_r.phase;
  assign arr_req_o.sector = s_r.sec;

  // status and forwarded command
  assign status_o.work_in_progress_bit = (s_r.st == sfesc_pkg::SFESC_ERASING)
    || (s_r.st == sfesc_pkg::SFESC_SUSPENDING) || prog_busy_i;
  assign status_o.erase_suspended = s_r.es;
  assign status_o.erase_err = s_r.eerr;
  assign status_o.prog_err = s_r.perr;
  assign status_o.write_enable_latch = s_r.we_latch;
  assign cmd_fwd_o = s_r.fwd;
  assign read_undef_o = s_r.rd_undef;

endmodule

//--- sim/sfesc_host.sv
// Purpose: host link model driving clock, select and io lanes
// Assumes: mode 0, link clock 48 ns, clock still between frames
// Notes: lanes show inverted junk while deselected
`timescale 1ns/1ps
module sfesc_host (
  input wire logic quad_i,  // four lanes per link clock
  output logic sclk_o,      // link clock, low between frames
  output logic cs_n_o,      // chip select, active low
  output logic [3:0] io_o   // io lanes
);
  // idle pins at time zero
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
  end
  // shift n bits of v msb first; keep leaves select low
  task automatic frame(input logic [63:0] v, input int n, input bit keep);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i += (quad_i ? 4 : 1))
    begin
      // quad: upper nibble first; serial: lane 0 only
      io_o = quad_i ? v[63:60] : {~io_o[3:1], v[63]};
      v = quad_i ? v << 4 : v << 1;
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    if (!keep)
      rel();
  endtask
  // raise select right after the last bit, then spoil the lanes
  task automatic rel();
    #24 cs_n_o = 1'b1;
    io_o = ~io_o;
    #100;
  endtask
endmodule

//--- sim/sfesc_ctrl_asserts.sv
// Purpose: port-level checks of the erase and suspend handler
// Assumes: one clock domain, sync reset
// Notes: bound to every sfesc_ctrl
`timescale 1ns/1ps
module sfesc_ctrl_asserts (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic quad_command_mode_i,
  input wire logic addr_len4_i,
  input wire logic [7:0] block_prot_i,
  input wire logic prog_busy_i,
  input wire logic arr_done_i,
  input sfesc_pkg::sfesc_arr_req_t arr_req_o,
  input sfesc_pkg::sfesc_cmd_t cmd_fwd_o,
  input sfesc_pkg::sfesc_status_t status_o,
  input wire logic read_undef_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // a requested array step means busy
  a_wip_on_req: assert property (arr_req_o.valid |-> status_o.work_in_progress_bit)
    else $error("busy low with array step requested");
  // busy only rises when select has been high
  a_start_cs: assert property ($rose(status_o.work_in_progress_bit) && !prog_busy_i
    |-> cs_n_i && $past(cs_n_i, 2)) else $error("erase started inside a frame");
  // pre-program is followed by erase of the same sector
  a_step_order: assert property (arr_done_i && arr_req_o.valid && !arr_req_o.erase
    |=> arr_req_o.erase && $stable(arr_req_o.sector)) else $error("bad step order");
  // after an erase step the next sector or the end
  a_sector_next: assert property (arr_done_i && arr_req_o.valid && arr_req_o.erase
    |=> !status_o.work_in_progress_bit || (!arr_req_o.erase
    && arr_req_o.sector == $past(arr_req_o.sector) + 6'h01)) else $error("bad next sector");
  // suspended erase requests nothing
  a_susp_noreq: assert property (status_o.erase_suspended |-> !arr_req_o.valid)
    else $error("array step while suspended");
  // suspended and not programming: not busy
  a_susp_nowip: assert property (status_o.erase_suspended && !prog_busy_i
    |-> !status_o.work_in_progress_bit) else $error("busy while suspended");
  // latch gone when an erase ends
  a_wel_clear: assert property ($fell(status_o.work_in_progress_bit)
    && !status_o.erase_suspended |-> !status_o.write_enable_latch)
    else $error("latch kept after erase");
  // forward pulse lasts one cycle, outside frames
  a_fwd_pulse: assert property (cmd_fwd_o.valid |-> cs_n_i ##1 !cmd_fwd_o.valid)
    else $error("forward pulse malformed");
  // undefined read flag only in suspension
  a_undef_susp: assert property (read_undef_o |-> status_o.erase_suspended)
    else $error("undefined read flag outside suspend");
  // program error rises only in suspension
  a_perr_susp: assert property ($rose(status_o.prog_err) |-> status_o.erase_suspended)
    else $error("program error outside suspend");
endmodule
bind sfesc_ctrl sfesc_ctrl_asserts sfesc_ctrl_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .io_i(io_i), .quad_command_mode_i(quad_command_mode_i),
  .addr_len4_i(addr_len4_i), .block_prot_i(block_prot_i), .prog_busy_i(prog_busy_i),
  .arr_done_i(arr_done_i), .arr_req_o(arr_req_o), .cmd_fwd_o(cmd_fwd_o),
  .status_o(status_o), .read_undef_o(read_undef_o));

//--- sim/tb_top.sv
// Purpose: self-checking bench of the erase and suspend handler
// Assumes: host model drives the link, bench the rest
// Notes: array steps are answered by bench done pulses
`timescale 1ns/1ps
`include "sfesc_defines.svh"
module tb_top;
  logic clk_sys_i = 1'b0; // system clock
  logic rst_i = 1'b1; // sync reset
  logic quad = 1'b0; // four-lane commands
  logic a4 = 1'b0; // address length config
  logic pb = 1'b0; // program engine busy
  logic done = 1'b0; // array step done
  logic [7:0] prot = 8'h00; // block protect bits
  logic sclk, cs_n, undef;
  logic [3:0] io;
  int fwd_cnt = 0; // forward pulses seen so far
  int fwd_base = 0; // pulse count at the start of the last frame
  logic fwd_seen; // a command was forwarded since the last frame began
  assign fwd_seen = (fwd_cnt != fwd_base);
  logic [7:0] reads [7] = '{8'h05, 8'h07, 8'h65, 8'h35, 8'h15, 8'h33, 8'h19};
  sfesc_pkg::sfesc_arr_req_t req;
  sfesc_pkg::sfesc_cmd_t fwd;
  sfesc_pkg::sfesc_status_t st;
  int n_errors = 0;
  int n_tests = 0;
  // system clock
  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // catch the one-cycle forward pulse
  always @(posedge clk_sys_i)
    if (fwd.valid === 1'b1)
      fwd_cnt <= fwd_cnt + 1;
  sfesc_host sfesc_host_i (.quad_i(quad), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(io));
  sfesc_ctrl sfesc_ctrl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(io), .quad_command_mode_i(quad), .addr_len4_i(a4),
    .block_prot_i(prot), .prog_busy_i(pb), .arr_done_i(done), .arr_req_o(req),
    .cmd_fwd_o(fwd), .status_o(st), .read_undef_o(undef));
  // compare one value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // one command frame: opcode, na address bits, nd data bits
  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input int na, nd,
    input bit keep = 1'b0);
    @(negedge clk_sys_i);
    fwd_base = fwd_cnt;
    sfesc_host_i.frame({op, ad << (32 - na), 24'h00_0000}, 8 + na + nd, keep);
    @(negedge clk_sys_i);
  endtask
  // answer cnt sectors of steps from sector first
  task automatic run(input int first, cnt);
    for (int s = first; s < first + cnt; s++)
      for (int ph = 0; ph < 2; ph++)
      begin
        for (int k = 0; k < 50 && req.valid !== 1'b1; k++)
          @(negedge clk_sys_i);
        chk("sector", 8'(s), req.sector);
        chk("phase", 8'(ph), req.erase);
        done = 1'b1;
        @(negedge clk_sys_i);
        done = 1'b0;
      end
    @(negedge clk_sys_i);
  endtask
  // verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #400_000;
    n_errors++;
    complete_run();
  end
  // tests
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("wip", 0, st.work_in_progress_bit);
    cmd(8'hd8, 32'h0080_0000, 24, 0);
    chk("wip", 0, st.work_in_progress_bit);
    quad = 1'b1;
    cmd(8'h06, 0, 0, 0);
    quad = 1'b0;
    chk("wel", 1, st.write_enable_latch);
    cmd(8'hd8, 32'h0080_0000, 32, 0);
    chk("wip", 0, st.work_in_progress_bit);
    $display("test refusals done");
    a4 = 1'b1;
    cmd(8'h06, 0, 0, 0);
    cmd(8'hd8, 32'h0100_0000, 32, 0);
    chk("wip", 1, st.work_in_progress_bit);
    run(16, 8);
    chk("wip", 0, st.work_in_progress_bit);
    chk("wel", 0, st.write_enable_latch);
    $display("test block erase done");
    prot = 8'h04;
    cmd(8'h06, 0, 0, 0);
    cmd(8'hdc, 32'h0100_0000, 32, 0);
    chk("err", 1, st.erase_err);
    chk("wel", 0, st.write_enable_latch);
    cmd(8'h30, 0, 0, 0);
    chk("err", 0, st.erase_err);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h60, 0, 0, 0);
    chk("err", 1, st.erase_err);
    cmd(8'h30, 0, 0, 0);
    prot = 8'h00;
    $display("test protection done");
    cmd(8'h06, 0, 0, 0);
    cmd(8'h60, 0, 0, 8);
    chk("wip", 0, st.work_in_progress_bit);
    cmd(8'hc7, 0, 0, 0);
    chk("wip", 1, st.work_in_progress_bit);
    cmd(8'h75, 0, 0, 0);
    chk("req", 1, req.valid);
    run(0, 64);
    chk("wip", 0, st.work_in_progress_bit);
    $display("test chip erase done");
    a4 = 1'b0;
    cmd(8'h06, 0, 0, 0);
    cmd(8'hd8, 32'h0080_0000, 24, 0);
    cmd(8'h75, 0, 0, 0);
    chk("req", 0, req.valid);
    chk("wip", 1, st.work_in_progress_bit);
    repeat (`SFESC_SUSP_LAT_CYC) @(negedge clk_sys_i);
    chk("wip", 0, st.work_in_progress_bit);
    chk("susp", 1, st.erase_suspended);
    cmd(8'h75, 0, 0, 0);
    chk("susp", 1, st.erase_suspended);
    foreach (reads[i])
    begin
      cmd(reads[i], 0, 24, 8);
      chk("fwd", 1, fwd_seen);
      chk("opcode", reads[i], fwd.opcode);
    end
    cmd(8'hab, 0, 0, 8);
    chk("fwd", 0, fwd_seen);
    cmd(8'h03, 32'h0080_0010, 24, 8, 1'b1);
    chk("undef", 1, undef);
    sfesc_host_i.rel();
    cmd(8'h03, 32'h0000_0010, 24, 8, 1'b1);
    chk("undef", 0, undef);
    sfesc_host_i.rel();
    chk("fwd", 1, fwd_seen);
    chk("addr", 8'h10, fwd.addr[7:0]);
    cmd(8'h02, 32'h0080_0000, 24, 8);
    chk("perr", 1, st.prog_err);
    cmd(8'h30, 0, 0, 0);
    pb = 1'b1;
    cmd(8'h7a, 0, 0, 0);
    chk("susp", 1, st.erase_suspended);
    pb = 1'b0;
    cmd(8'h7a, 0, 0, 0);
    chk("susp", 0, st.erase_suspended);
    chk("wip", 1, st.work_in_progress_bit);
    run(8, 8);
    cmd(8'h7a, 0, 0, 0);
    chk("wip", 0, st.work_in_progress_bit);
    $display("test suspend done");
    complete_run();
  end
endmodule
